// file: bench/tb_top.sv
/* Self-checking bench for the transmit indicator selector.
   Assumes the design, the model and the checker compile first. */
`timescale 1ns/1ps
module tb_top;
  import tmf_pkg::*;
  typedef struct {tmf_byte_t cfg; logic [4:0] lv; logic ind, oe;} tmf_row_s;
  logic      sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  tmf_byte_t reg_wdata = 8'h00, reg_rdata;
  logic [4:0] lv = 5'h00;
  logic [2:0] ev = 3'h0;
  logic      tx_negative_rail_input = 1'b1;
  logic      irq, tx_multifunction_indicator, tx_indicator_oe, neg_rail_data;
  logic      pattern_sync, pattern_error, system_side_alarm_indication;
  logic      transmit_overcurrent, tx_line_signal_loss, system_signal_loss;
  logic      system_excess_zeroes, system_bipolar_violation;
  int        fail_count = 0, n_compared = 0;
  // Level selections: config, levels, indicator and pin enable expected
  tmf_row_s rows [11] = '{'{8'h20, 5'h08, 1, 1}, '{8'h20, 5'h17, 0, 1}, '{8'h23, 5'h08, 1, 0},
    '{8'h42, 5'h04, 1, 1}, '{8'h42, 5'h1B, 0, 1}, '{8'h61, 5'h02, 1, 0},
    '{8'h61, 5'h1D, 0, 0}, '{8'hE2, 5'h01, 1, 1}, '{8'hE0, 5'h01, 0, 1},
    '{8'h00, 5'h10, 1, 1}, '{8'h00, 5'h0F, 0, 1}};
  tmf_far far (.*);
  tmf_sel dut (.*);
  task automatic chk(input string nm, input logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e, input string nm);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata, e);
  endtask
  // Fire one event and count indicator cycles at the given level
  task automatic fire(input logic [7:0] c, input logic [2:0] e, input int n, input logic p);
    int k;
    wr(8'h00, c);
    cyc(16);
    ev <= e;
    @(posedge sys_clk);
    ev <= 3'h0;
    k = 0;
    repeat (20) begin
      @(posedge sys_clk);
      #1 k += int'(tx_multifunction_indicator === p);
    end
    chk("pulse cycles", k[7:0], n[7:0]);
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial forever #50 sys_clk = ~sys_clk;
  // Watchdog well beyond the expected run
  initial begin
    cyc(5000);
    fail_count++;
    conclude();
  end
  initial begin
    cyc(7);
    #1 chk("enable in reset", tx_indicator_oe, 8'h00);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(8'h00, rows[i].cfg);
      lv <= rows[i].lv;
      cyc(4);
      #1 chk("indicator", tx_multifunction_indicator, rows[i].ind);
      chk("pin enable", tx_indicator_oe, rows[i].oe);
      chk("rail data", neg_rail_data, !rows[i].oe);
    end
    lv <= 5'h00;
    fire(8'h82, 3'h2, 6, 1'b1);
    fire(8'h86, 3'h2, 4, 1'b1);
    fire(8'hA2, 3'h1, 6, 1'b1);
    fire(8'hA2, 3'h2, 0, 1'b1);
    fire(8'hC2, 3'h2, 6, 1'b1);
    fire(8'hC2, 3'h3, 6, 1'b1);
    fire(8'hC0, 3'h3, 0, 1'b1);
    lv <= 5'h10;
    fire(8'h02, 3'h4, 6, 1'b0);
    fire(8'h06, 3'h4, 4, 1'b0);
    lv <= 5'h0F;
    cyc(4);
    rd(8'h01, 8'h16, "status zero");
    rd(8'h02, 8'h80, "status one");
    rd(8'h07, 8'h00, "unmapped read");
    cyc(1);
    #1 chk("read data after", reg_rdata, 8'h00);
    wr(8'h07, 8'hFF);
    rd(8'h00, 8'h06, "config one");
    lv <= 5'h00;
    cyc(4);
    wr(8'h03, 8'hFF);
    wr(8'h04, 8'h10);
    cyc(2);
    #1 chk("irq idle", irq, 8'h00);
    lv <= 5'h06;
    cyc(4);
    #1 chk("irq raised", irq, 8'h01);
    rd(8'h03, 8'h14, "event status");
    wr(8'h03, 8'h10);
    cyc(2);
    #1 chk("irq masked", irq, 8'h00);
    rd(8'h03, 8'h04, "status after clear");
    conclude();
  end
endmodule // tb_top

// file: bench/tmf_far.sv
/* Model of the transmit path logic feeding the indicator selector.
   Assumes the bench requests events for one cycle at a time. */
`timescale 1ns/1ps
module tmf_far (
  input  wire logic       sys_clk,
  input  wire logic [4:0] lv,  // Levels: sync, alarm, overcurrent, line, system
  input  wire logic [2:0] ev,  // Events: pattern error, excess zeroes, violation
  output logic            pattern_sync,
  output logic            pattern_error,
  output logic            system_side_alarm_indication,
  output logic            transmit_overcurrent,
  output logic            tx_line_signal_loss,
  output logic            system_excess_zeroes,
  output logic            system_bipolar_violation,
  output logic            system_signal_loss
);
  // Levels and events leave on the clock; errors only exist in sync
  always_ff @(posedge sys_clk) begin
    {pattern_sync, system_side_alarm_indication, transmit_overcurrent,
     tx_line_signal_loss, system_signal_loss} <= lv;
    pattern_error            <= ev[2] & lv[4];
    system_excess_zeroes     <= ev[1];
    system_bipolar_violation <= ev[0];
  end
endmodule // tmf_far

// file: bench/tmf_sel_assertions.sv
/* Port checker for the indicator selector, bound below.
   Assumes config one sits at offset 00. */
`timescale 1ns/1ps
module tmf_sel_assertions (
  input wire logic               sys_clk,
  input wire logic               rst_n,
  input wire logic [7:0]         reg_addr,
  input wire tmf_pkg::tmf_byte_t reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire tmf_pkg::tmf_byte_t reg_rdata,
  input wire logic               irq,
  input wire logic               pattern_sync,
  input wire logic               pattern_error,
  input wire logic               system_side_alarm_indication,
  input wire logic               transmit_overcurrent,
  input wire logic               tx_line_signal_loss,
  input wire logic               system_excess_zeroes,
  input wire logic               system_bipolar_violation,
  input wire logic               system_signal_loss,
  input wire logic               tx_negative_rail_input,
  input wire logic               tx_multifunction_indicator,
  input wire logic               tx_indicator_oe,
  input wire logic               neg_rail_data
);
  logic [7:0] cfg, cfg_d;  // Shadow of config one, and one cycle late
  logic       ok1, ok;     // Two edges clear of reset
  logic [4:0] quiet;       // Cycles since the last event
  wire [2:0] sel = cfg_d[7:5];
  wire [1:0] fmt = cfg_d[1:0];
  wire       ind = tx_multifunction_indicator;
  wire       ev  = system_excess_zeroes | system_bipolar_violation | pattern_error;
  // Shadow config and event gap counter
  always_ff @(posedge sys_clk) begin
    ok1   <= rst_n;
    ok    <= rst_n & ok1;
    cfg_d <= cfg;
    if (!rst_n) begin
      cfg   <= 8'h00;
      quiet <= 5'h00;
    end else begin
      if (reg_wr && reg_addr == 8'h00) cfg <= reg_wdata;
      quiet <= ev ? 5'h00 : quiet + {4'h0, quiet != 5'h1F};
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_ais_mirror: assert property (ok && sel == 3'h1 |->
    ind == $past(system_side_alarm_indication)) else $error("Alarm level not followed");
  a_oc_mirror: assert property (ok && sel == 3'h2 |->
    ind == $past(transmit_overcurrent)) else $error("Overcurrent not followed");
  a_system_signal_loss_mirror: assert property (ok && sel == 3'h7 && fmt != 2'h0 |->
    ind == $past(system_signal_loss)) else $error("System loss not followed");
  a_sr_blanked: assert property (ok && fmt == 2'h0 && sel > 3'h4 |-> !ind)
    else $error("Blanked selection drives indicator");
  a_pin_owner: assert property (ok |-> tx_indicator_oe == (fmt == 2'h0 || fmt == 2'h2))
    else $error("Pin enable wrong for format");
  a_sync_low: assert property (ok && sel == 3'h0 && !$past(pattern_sync) |-> !ind)
    else $error("Indicator high out of sync");
  a_evt_shows: assert property (ok && quiet > 5'h0E && fmt != 2'h0 && sel inside {3'h4, 3'h5,
    3'h6} && (system_excess_zeroes && sel != 3'h5 || system_bipolar_violation && sel != 3'h4)
    |-> ##[1:9] ind) else $error("Event pulse missing");
  a_t1_width: assert property (ok && $rose(ind) && sel inside {3'h4, 3'h5, 3'h6} && !cfg_d[2]
    |-> ind[*6] ##1 !ind) else $error("Event pulse width wrong");
  c_evt_pulse: cover property (ok && sel == 3'h4 && $rose(ind));
  c_pin_line: cover property (ok && !tx_indicator_oe && neg_rail_data);
  c_irq_up: cover property ($rose(irq));
endmodule // tmf_sel_assertions

bind tmf_sel tmf_sel_assertions chk (.*);

// file: hw/tmf_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the
  transmit indicator selector. Assumes an 8-bit register port.
*/
`ifndef TMF_CFG_SVH
`define TMF_CFG_SVH

// Register offsets
`define TMF_OFS_CFG1   8'h00
`define TMF_OFS_STATUS_REG_ZERO  8'h01
`define TMF_OFS_STATUS_REG_ONE  8'h02
`define TMF_OFS_ISTAT  8'h03
`define TMF_OFS_IMASK  8'h04

// Config one fields
`define TMF_SEL_HI     7
`define TMF_SEL_LO     5
`define TMF_E1_BIT     2
`define TMF_FMT_HI     1
`define TMF_FMT_LO     0
`define TMF_CFG1_RST   8'h00

// Status bit positions
`define TMF_OC_BIT     4
`define TMF_TX_LINE_SIGNAL_LOSS_BIT   2
`define TMF_SYSTEM_SIGNAL_LOSS_BIT   1
`define TMF_AIS_BIT    7

// Line clock periods and system clock period, in ns
`define TMF_SYS_NS     100
`define TMF_T1_NS      648
`define TMF_E1_NS      488
`define TMF_T1_DIV     (`TMF_T1_NS / `TMF_SYS_NS)
`define TMF_E1_DIV     (`TMF_E1_NS / `TMF_SYS_NS)

`endif

// file: hw/tmf_pace.sv
/*
  Line clock divider and event pacer: turns single-cycle events into
  levels that last one line period cut to whole system clocks: 6 for T1, 4 for E1.
  Assumes events come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "tmf_cfg.svh"
module tmf_pace (
  input wire logic  sys_clk,
  input wire logic  rst_n,
  tmf_pace_if.pace  pc
);
  import tmf_pkg::*;

  localparam logic [3:0] T1_DIV = 4'(`TMF_T1_DIV);
  localparam logic [3:0] E1_DIV = 4'(`TMF_E1_DIV);

  logic [3:0] div_cnt;       // Divider count
  logic [3:0] next_div_cnt;
  logic       tick;          // Line enable
  logic       next_tick;
  logic [2:0] pend;          // Events waiting for the next tick
  logic [2:0] next_pend;
  logic [2:0] hold;          // Events shown this line period
  logic [2:0] next_hold;

  // Divider and pacing next values
  always_comb begin
    next_tick = 1'b0;
    next_div_cnt = div_cnt + 4'h1;
    // Wrap at one line period
    if (div_cnt >= (pc.e1_mode ? E1_DIV : T1_DIV) - 4'h1) begin
      next_div_cnt = 4'h0;
      next_tick = 1'b1;
    end
    next_hold = hold;
    next_pend = pend | pc.evt;
    // New period: show what waited, keep events of this cycle
    if (tick) begin
      next_hold = pend;
      next_pend = pc.evt;
    end
  end

  // Registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_cnt <= 4'h0;
      tick    <= 1'b0;
      pend    <= 3'h0;
      hold    <= 3'h0;
    end else begin
      div_cnt <= next_div_cnt;
      tick    <= next_tick;
      pend    <= next_pend;
      hold    <= next_hold;
    end
  end

  assign pc.tick    = tick;
  assign pc.stretch = hold;
endmodule // tmf_pace

// file: hw/tmf_pace_if.sv
/*
  Carries line-rate pacing between the selector and its pulse pacer.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface tmf_pace_if;
  logic       e1_mode;   // Line rate is E1
  logic [2:0] evt;       // Raw events: error, exz, bpv
  logic [2:0] stretch;   // Events held one line period
  logic       tick;      // Line clock enable

  modport host (output e1_mode, output evt, input stretch, input tick);
  modport pace (input e1_mode, input evt, output stretch, output tick);
endinterface

// file: hw/tmf_pkg.sv
/*
  Types of the transmit indicator selector.
  Assumes nothing of its surroundings.
*/
package tmf_pkg;
  // Indicator selection codes
  typedef enum logic [2:0] {
    TMF_SEL_PATTERN = 3'h0,
    TMF_SEL_AIS     = 3'h1,
    TMF_SEL_OC      = 3'h2,
    TMF_SEL_TX_LINE_SIGNAL_LOSS    = 3'h3,
    TMF_SEL_EXZ     = 3'h4,
    TMF_SEL_BPV     = 3'h5,
    TMF_SEL_BOTH    = 3'h6,
    TMF_SEL_SYSTEM_SIGNAL_LOSS    = 3'h7
  } tmf_sel_e;

  // Transmit system interface formats
  typedef enum logic [1:0] {
    TMF_FMT_SR_NRZ = 2'h0,
    TMF_FMT_DR_NRZ = 2'h1,
    TMF_FMT_DR_RZ  = 2'h2,
    TMF_FMT_RSVD   = 2'h3
  } tmf_fmt_e;

  typedef logic [7:0] tmf_byte_t;
endpackage

// file: hw/tmf_sel.sv
/*
  Transmit multifunction indicator selector with its register port
  and interrupt logic. Assumes condition inputs come from transmit
  path logic on sys_clk and the negative rail pin is asynchronous.
*/
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "tmf_cfg.svh"
// Summary of operation
// RULE1: indicator drives shared pin only in two formats
// RULE2: select field in config one bits 7..5
// RULE3: single-rail NRZ disables violation, combined, system loss
// RULE4: pattern selection high while checker synchronized
// RULE5: pattern error drives low one line cycle
// RULE6: pattern selection low when out of sync
// RULE7: code 001 mirrors alarm status bit 7
// RULE8: over-current selection mirrors status zero bit 4
// RULE9: line loss selection mirrors status zero bit 2
// RULE10: excess zeroes pulse one line cycle
// RULE11: violation pulses one line cycle
// RULE12: combined selection pulses on either event
// RULE13: system loss selection mirrors status zero bit 1
// RULE14: select codes map in listed order
module tmf_sel (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire tmf_pkg::tmf_byte_t reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output tmf_pkg::tmf_byte_t reg_rdata,
  output logic             irq,
  // Transmit path conditions
  input  wire logic        pattern_sync,
  input  wire logic        pattern_error,
  input  wire logic        system_side_alarm_indication,
  input  wire logic        transmit_overcurrent,
  input  wire logic        tx_line_signal_loss,
  input  wire logic        system_excess_zeroes,
  input  wire logic        system_bipolar_violation,
  input  wire logic        system_signal_loss,
  // Shared pin
  input  wire logic        tx_negative_rail_input,
  output logic             tx_multifunction_indicator,
  output logic             tx_indicator_oe,
  output logic             neg_rail_data
);
  import tmf_pkg::*;

  tmf_pace_if pc ();                // Pacing link

  tmf_byte_t cfg1;                  // Config one
  tmf_byte_t next_cfg1;
  tmf_byte_t istat;                 // Sticky events
  tmf_byte_t next_istat;
  tmf_byte_t imask;                 // Interrupt mask
  tmf_byte_t next_imask;
  tmf_byte_t rdata;                 // Read data
  tmf_byte_t next_rdata;
  logic      irq_q;                 // Interrupt level
  logic      next_irq;
  tmf_byte_t status_reg_zero;                 // Live status zero
  tmf_byte_t status_reg_one;                 // Live status one
  tmf_byte_t evt_vec;               // Events this cycle
  logic [4:0] lvl_q;                // Previous levels
  logic [4:0] lvl_now;              // Current levels
  logic       neg_meta;             // Pin sync first stage
  logic       neg_sync;             // Pin sync second stage
  logic       neg_q;                // Sampled rail data
  logic       next_neg;
  logic       ind_q;                // Indicator
  logic       next_ind;
  logic       oe_q;                 // Pin drive enable
  logic       next_oe;
  tmf_sel_e   sel;                  // Selected condition
  tmf_fmt_e   fmt;                  // Transmit format

  // Field decode
  assign sel = tmf_sel_e'(cfg1[`TMF_SEL_HI:`TMF_SEL_LO]); // [RULE2]
  assign fmt = tmf_fmt_e'(cfg1[`TMF_FMT_HI:`TMF_FMT_LO]);

  // Pacer link
  assign pc.e1_mode = cfg1[`TMF_E1_BIT];
  assign pc.evt = {pattern_error & pattern_sync,
                   system_excess_zeroes,
                   system_bipolar_violation};

  tmf_pace u_pace (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pc      (pc)
  );

  // Status registers as software sees them
  always_comb begin
    status_reg_zero = 8'h00;
    status_reg_zero[`TMF_OC_BIT]   = transmit_overcurrent;
    status_reg_zero[`TMF_TX_LINE_SIGNAL_LOSS_BIT] = tx_line_signal_loss;
    status_reg_zero[`TMF_SYSTEM_SIGNAL_LOSS_BIT] = system_signal_loss;
    status_reg_one = 8'h00;
    status_reg_one[`TMF_AIS_BIT]  = system_side_alarm_indication;
  end

  // Level conditions watched for rising edges, sync for its fall
  assign lvl_now = {system_side_alarm_indication,
                    transmit_overcurrent,
                    tx_line_signal_loss,
                    system_signal_loss,
                    pattern_sync};

  // Interrupt events: rises, sync loss, pulses
  always_comb begin
    evt_vec = 8'h00;
    evt_vec[7] = lvl_now[4] & ~lvl_q[4];
    evt_vec[4] = lvl_now[3] & ~lvl_q[3];
    evt_vec[2] = lvl_now[2] & ~lvl_q[2];
    evt_vec[1] = lvl_now[1] & ~lvl_q[1];
    evt_vec[0] = ~lvl_now[0] & lvl_q[0];
    evt_vec[3] = pattern_error & pattern_sync;
    evt_vec[5] = system_excess_zeroes;
    evt_vec[6] = system_bipolar_violation;
  end

  // Register port next values
  always_comb begin
    next_cfg1  = cfg1;
    next_imask = imask;
    next_istat = istat;
    next_rdata = 8'h00;
    // Writes
    if (reg_wr) begin
      unique case (reg_addr)
        `TMF_OFS_CFG1: begin
          next_cfg1 = reg_wdata;
        end
        `TMF_OFS_IMASK: begin
          next_imask = reg_wdata;
        end
        `TMF_OFS_ISTAT: begin
          // Write one to clear
          next_istat = istat & ~reg_wdata;
        end
        default: begin
          next_cfg1 = cfg1;
        end
      endcase
    end
    // Set wins over clear
    next_istat = next_istat | evt_vec;
    // Reads, answered next cycle
    if (reg_rd) begin
      unique case (reg_addr)
        `TMF_OFS_CFG1:  next_rdata = cfg1;
        `TMF_OFS_STATUS_REG_ZERO: next_rdata = status_reg_zero;
        `TMF_OFS_STATUS_REG_ONE: next_rdata = status_reg_one;
        `TMF_OFS_ISTAT: next_rdata = istat;
        `TMF_OFS_IMASK: next_rdata = imask;
        default:        next_rdata = 8'h00;
      endcase
    end
    next_irq = |(next_istat & next_imask);
  end

  // Register port registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg1  <= `TMF_CFG1_RST;
      imask <= 8'h00;
      istat <= 8'h00;
      rdata <= 8'h00;
      irq_q <= 1'b0;
      lvl_q <= 5'h00;
    end else begin
      cfg1  <= next_cfg1;
      imask <= next_imask;
      istat <= next_istat;
      rdata <= next_rdata;
      irq_q <= next_irq;
      lvl_q <= lvl_now;
    end
  end

  // Indicator selection
  always_comb begin
    next_ind = 1'b0;
    unique case (sel) // [RULE14]
      TMF_SEL_PATTERN: begin
        // High in sync, low one line cycle per error, low out of sync
        next_ind = pattern_sync & ~pc.stretch[2]; // [RULE4] [RULE5] [RULE6]
      end
      TMF_SEL_AIS: begin
        next_ind = status_reg_one[`TMF_AIS_BIT]; // [RULE7]
      end
      TMF_SEL_OC: begin
        next_ind = status_reg_zero[`TMF_OC_BIT]; // [RULE8]
      end
      TMF_SEL_TX_LINE_SIGNAL_LOSS: begin
        next_ind = status_reg_zero[`TMF_TX_LINE_SIGNAL_LOSS_BIT]; // [RULE9]
      end
      TMF_SEL_EXZ: begin
        next_ind = pc.stretch[1]; // [RULE10]
      end
      TMF_SEL_BPV: begin
        next_ind = pc.stretch[0]; // [RULE11]
      end
      TMF_SEL_BOTH: begin
        next_ind = pc.stretch[1] | pc.stretch[0]; // [RULE12]
      end
      TMF_SEL_SYSTEM_SIGNAL_LOSS: begin
        next_ind = status_reg_zero[`TMF_SYSTEM_SIGNAL_LOSS_BIT]; // [RULE13]
      end
    endcase
    // Single-rail NRZ: three selections forced off
    if (fmt == TMF_FMT_SR_NRZ &&
        (sel == TMF_SEL_BPV || sel == TMF_SEL_BOTH ||
         sel == TMF_SEL_SYSTEM_SIGNAL_LOSS)) begin
      next_ind = 1'b0; // [RULE3]
    end
  end

  // Pin ownership: drive in single-rail NRZ and dual-rail RZ
  always_comb begin
    next_oe = (fmt == TMF_FMT_SR_NRZ) ||
              (fmt == TMF_FMT_DR_RZ); // [RULE1]
    // Rail data is only taken while the pin is an input
    next_neg = next_oe ? 1'b0 : neg_sync;
  end

  // Pin registers and synchroniser
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      neg_meta <= 1'b0;
      neg_sync <= 1'b0;
      neg_q    <= 1'b0;
      ind_q    <= 1'b0;
      oe_q     <= 1'b0;
    end else begin
      neg_meta <= tx_negative_rail_input;
      neg_sync <= neg_meta;
      neg_q    <= next_neg;
      ind_q    <= next_ind;
      oe_q     <= next_oe;
    end
  end

  // Outputs straight from flops
  assign tx_multifunction_indicator = ind_q;
  assign tx_indicator_oe            = oe_q;
  assign neg_rail_data              = neg_q;
  assign reg_rdata                  = rdata;
  assign irq                        = irq_q;
endmodule // tmf_sel
